// ---- pkg/dp_pkg.sv ----
// Shared constants and types of the configurable logic tile.
package dp_pkg;

	//--------------------------------------------------------------
	// Sizes
	//--------------------------------------------------------------
	localparam int DATA_W      = 8;
	localparam int QUEUE_DEPTH = 4;
	localparam int PT_INPUTS   = 12;
	localparam int PT_TERMS    = 8;
	localparam int PLA_OUTS    = 4;
	localparam int CFG_WORDS   = 8;
	localparam int CFG_AW      = 3;
	localparam int ROUTE_OUTS  = 6;
	localparam int COND_NUM    = 16;

	//--------------------------------------------------------------
	// Register addresses, reset values and fixed codes
	//--------------------------------------------------------------
	localparam logic [2:0] ADDR_ACC [2]   = '{3'h0, 3'h1};
	localparam logic [2:0] ADDR_OPR [2]   = '{3'h2, 3'h3};
	localparam logic [2:0] ADDR_QUEUE [2] = '{3'h4, 3'h5};
	localparam logic [2:0] ADDR_STATUS    = 3'h6;
	localparam logic [7:0] BYTE_RESET     = 8'h00;
	localparam logic [15:0] CFG_RESET     = 16'h0000;
	localparam logic [2:0] MSB_TOP        = 3'h7;
	localparam logic [3:0] COND_ZERO0     = 4'h4;

	//--------------------------------------------------------------
	// Types
	//--------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_PASS = 3'h0, OP_INC = 3'h1, OP_DEC = 3'h2, OP_ADD = 3'h3,
		OP_SUB  = 3'h4, OP_AND = 3'h5, OP_OR  = 3'h6, OP_XOR = 3'h7
	} alu_op_e;
	typedef enum logic [1:0] {
		SH_NONE = 2'h0, SH_LEFT = 2'h1, SH_RIGHT = 2'h2, SH_SWAP = 2'h3
	} shift_e;
	typedef enum logic [1:0] {
		ACC_HOLD = 2'h0, ACC_ALU = 2'h1, ACC_QUEUE = 2'h2, ACC_OPERAND = 2'h3
	} acc_src_e;
	typedef enum logic [1:0] {
		PAIR_A0_D0 = 2'h0, PAIR_A1_D1 = 2'h1, PAIR_A0_A1 = 2'h2,
		PAIR_A1_D0 = 2'h3
	} cmp_pair_e;

	typedef struct packed {
		alu_op_e          op;
		logic             a_sel;
		logic [1:0]       b_sel;
		shift_e           shift;
		logic [1:0][1:0]  acc_src;
		logic             dreg_load;
		logic             queue_push;
		logic             carry_reg;
		logic             crc_en;
	} cfg_word_s;

	typedef struct packed {
		logic [1:0]                  q_out_dir;
		logic [1:0]                  q_cap_alu;
		logic                        mask_en;
		logic                        chain_en;
		logic [2:0]                  msb;
		logic [7:0]                  or_mask;
		logic [7:0]                  poly;
		logic [1:0][7:0]             cmp_mask;
		logic [1:0][1:0]             cmp_pair;
		logic [ROUTE_OUTS-1:0][3:0]  out_sel;
	} static_cfg_s;

	typedef struct packed {
		logic [PT_TERMS-1:0][PT_INPUTS-1:0] use_true;
		logic [PT_TERMS-1:0][PT_INPUTS-1:0] use_comp;
		logic [PLA_OUTS-1:0][PT_TERMS-1:0]  sum_en;
		logic [PLA_OUTS-1:0]                reg_out;
	} pla_cfg_s;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [2:0]  addr;
		logic [7:0]  wdata;
	} bus_req_s;

endpackage

// ---- rtl/product_term_array.sv ----
// Sum-of-products array with a choice of registered or direct outputs.
module product_term_array
	import dp_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 clk_en,
	input  wire logic                 sys_rst,
	input  wire pla_cfg_s             cfg,
	input  wire logic [PT_INPUTS-1:0] pla_in,
	output wire logic [PLA_OUTS-1:0]  pla_out
);
	logic [PT_TERMS-1:0] term;
	logic [PLA_OUTS-1:0] sum_c;
	logic [PLA_OUTS-1:0] sum_q;

	genvar t, o;
	generate
		for (t = 0; t < PT_TERMS; t++) begin : g_term
			assign term[t] = (&(~cfg.use_true[t] | pla_in))
				& (&(~cfg.use_comp[t] | ~pla_in));
		end
		for (o = 0; o < PLA_OUTS; o++) begin : g_sum
			assign sum_c[o] = |(cfg.sum_en[o] & term);
			assign pla_out[o] = cfg.reg_out[o] ? sum_q[o] : sum_c[o];
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sum_q <= '0;
		end else if (clk_en) begin
			sum_q <= sum_c;
		end
	end

	pla_sum_a: assert property (@(posedge clk) disable iff (sys_rst)
		(|(cfg.sum_en[0] & term)) && !cfg.reg_out[0] |-> pla_out[0])
		else $error("array output low with an active product term");
	pla_reg_c: cover property (@(posedge clk) cfg.reg_out[0] && pla_out[0]);
endmodule

// ---- rtl/byte_queue.sv ----
// Small first-in first-out byte store held in flip-flops.
module byte_queue
	import dp_pkg::*;
#(
	parameter int WIDTH = DATA_W,
	parameter int DEPTH = QUEUE_DEPTH
)(
	input  wire logic             clk,
	input  wire logic             clk_en,
	input  wire logic             sys_rst,
	input  wire logic             push,
	input  wire logic [WIDTH-1:0] push_data,
	input  wire logic             pop,
	output wire logic [WIDTH-1:0] head,
	output wire logic             full,
	output wire logic             empty
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
	localparam logic [PTR_W:0]   CNT_FULL = (PTR_W + 1)'(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PTR_W-1:0] wr_q;
	logic [PTR_W-1:0] rd_q;
	logic [PTR_W:0]   cnt_q;

	wire do_push = push && !full;
	wire do_pop  = pop && !empty;
	wire [PTR_W-1:0] wr_nx = (wr_q == PTR_LAST) ? '0 : PTR_W'(wr_q + 1'b1);
	wire [PTR_W-1:0] rd_nx = (rd_q == PTR_LAST) ? '0 : PTR_W'(rd_q + 1'b1);
	wire [PTR_W:0] cnt_nx = do_push && !do_pop ? (PTR_W + 1)'(cnt_q + 1'b1)
		: do_pop && !do_push ? (PTR_W + 1)'(cnt_q - 1'b1) : cnt_q;

	assign full  = (cnt_q == CNT_FULL);
	assign empty = (cnt_q == '0);
	assign head  = mem_q[rd_q];

	always_ff @(posedge clk) begin
		if (do_push && clk_en) begin
			mem_q[wr_q] <= push_data;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else if (clk_en) begin
			wr_q  <= do_push ? wr_nx : wr_q;
			rd_q  <= do_pop ? rd_nx : rd_q;
			cnt_q <= cnt_nx;
		end
	end

	queue_full_a: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && full && push && !pop |=> full && $stable(wr_q))
		else $error("push into a full queue changed it");
	queue_full_c: cover property (@(posedge clk) full);
endmodule

// ---- rtl/programmable_logic_datapath.sv ----
// Configurable logic tile: two product term arrays and an 8-bit datapath.
//----------------------------------------------------------------------
// How it works
// - Each logic array takes twelve routed inputs feeding eight product terms.
// - Each product term ANDs chosen inputs, each true or complemented.
// - Each array output ORs up to eight terms; same width for all.
// - Two arrays per tile; each output registered or combinational.
// - The 8-bit ALU finishes one operation per clock, with conditions.
// - Accumulators feed the ALU, take its result and feed compares.
// - Operand registers feed ALU and compares, never take the result.
// - Queues load operand registers or accumulators, or capture results.
// - Two queues, each four bytes deep.
// - Each queue is an input (bus writes) or output (bus reads) buffer.
// - Queue full and empty flags can be routed out.
// - Eight 16-bit configuration words; routed address picks one per cycle.
// - ALU: increment, decrement, add, subtract, AND, OR, XOR, pass.
// - After the ALU: shift left, shift right, nibble swap, OR mask.
// - Two masked compares on selectable accumulator and operand pairs.
// - Zero, all-ones and overflow conditions; a selection is routed out.
// - The most significant bit for arithmetic and shifts is configurable.
// - One CRC or pseudo random sequence step per cycle, any polynomial.
// - Carry, shift data and compare equality chain to neighbours.
// - Carry and shift out are registered and usable as later inputs.
//----------------------------------------------------------------------
module programmable_logic_datapath
	import dp_pkg::*;
(
	input  wire logic                       clk,
	input  wire logic                       clk_en,
	input  wire logic                       sys_rst,
	input  wire bus_req_s                   bus_req,
	output wire logic [DATA_W-1:0]          bus_rdata,
	input  wire logic                       cfg_we,
	input  wire logic [CFG_AW-1:0]          cfg_addr,
	input  wire cfg_word_s                  cfg_wdata,
	input  wire static_cfg_s                static_cfg,
	input  wire pla_cfg_s [1:0]             pla_cfg,
	input  wire logic [1:0][PT_INPUTS-1:0]  pla_in,
	output wire logic [1:0][PLA_OUTS-1:0]   pla_out,
	input  wire logic [CFG_AW-1:0]          route_addr,
	input  wire logic                       route_ci,
	input  wire logic                       route_si,
	output wire logic [ROUTE_OUTS-1:0]      route_out,
	input  wire logic                       chain_ci,
	input  wire logic                       chain_si,
	input  wire logic                       chain_eq_in,
	output wire logic                       chain_co,
	output wire logic                       chain_so,
	output wire logic                       chain_eq_out
);
	//------------------------------------------------------------------
	// State
	//------------------------------------------------------------------
	cfg_word_s        cfg_ram_q [CFG_WORDS];
	logic [7:0]       acc_q [2];
	logic [7:0]       dreg_q [2];
	logic             carry_q;
	logic             shift_q;
	logic [ROUTE_OUTS-1:0] route_out_q;
	logic [7:0]       rdata_q;

	wire [7:0]        q_head [2];
	wire [1:0]        q_full;
	wire [1:0]        q_empty;
	wire [COND_NUM-1:0] cond;
	wire [ROUTE_OUTS-1:0] route_pick;
	wire [1:0]        cmp_eq;
	wire [1:0]        cmp_lt;

	//------------------------------------------------------------------
	// Logic arrays
	//------------------------------------------------------------------
	genvar p;
	generate
		for (p = 0; p < 2; p++) begin : g_pla
			product_term_array u_pla (
				.clk     (clk),
				.clk_en  (clk_en),
				.sys_rst (sys_rst),
				.cfg     (pla_cfg[p]),
				.pla_in  (pla_in[p]),
				.pla_out (pla_out[p])
			);
		end
	endgenerate

	//------------------------------------------------------------------
	// Operand selection
	//------------------------------------------------------------------
	cfg_word_s word;
	assign word = cfg_ram_q[route_addr];

	wire [2:0] msb = static_cfg.msb;
	wire [7:0] width_mask = 8'hFF >> (MSB_TOP - msb);
	wire [7:0] msb_bit = 8'h01 << msb;
	wire [7:0] opa = word.a_sel ? acc_q[1] : acc_q[0];
	wire [7:0] opb = word.b_sel[1] ? acc_q[word.b_sel[0]]
		: dreg_q[word.b_sel[0]];
	wire [7:0] am = opa & width_mask;
	wire [7:0] bm = opb & width_mask;
	wire cin = word.carry_reg ? carry_q
		: (static_cfg.chain_en ? chain_ci : route_ci);
	wire sin = word.carry_reg ? shift_q
		: (static_cfg.chain_en ? chain_si : route_si);

	//------------------------------------------------------------------
	// ALU
	//------------------------------------------------------------------
	logic [7:0] b_eff;
	logic       c_eff;
	logic       arith;
	logic [8:0] sum9;
	logic [7:0] alu_res;

	always_comb begin
		b_eff = bm;
		c_eff = 1'b0;
		arith = 1'b1;
		case (word.op)
			OP_INC:  b_eff = 8'h01;
			OP_DEC:  b_eff = width_mask;
			OP_ADD:  c_eff = cin;
			OP_SUB: begin
				b_eff = ~bm & width_mask;
				c_eff = cin;
			end
			default: arith = 1'b0;
		endcase
		sum9 = {1'b0, am} + {1'b0, b_eff} + {8'h00, c_eff};
		case (word.op)
			OP_AND:  alu_res = am & bm;
			OP_OR:   alu_res = am | bm;
			OP_XOR:  alu_res = am ^ bm;
			OP_PASS: alu_res = am;
			default: alu_res = sum9[7:0] & width_mask;
		endcase
	end
	wire [3:0] co_idx = {1'b0, msb} + 4'h1;
	wire carry_out = arith & sum9[co_idx];
	wire overflow = arith & (am[msb] == b_eff[msb])
		& (alu_res[msb] != am[msb]);
	// One linear feedback step; with sin held low it walks the sequence.
	wire fb = am[msb] ^ sin;
	wire [7:0] crc_res = ({am[6:0], 1'b0} ^ (fb ? static_cfg.poly : 8'h00))
		& width_mask;
	wire [7:0] core = word.crc_en ? crc_res : alu_res;
	//------------------------------------------------------------------
	// Shifter and mask
	//------------------------------------------------------------------
	wire [7:0] sh_left  = {core[6:0], sin} & width_mask;
	wire [7:0] sh_right = {1'b0, core[7:1]} | (sin ? msb_bit : 8'h00);
	wire [7:0] sh_swap  = {core[3:0], core[7:4]};
	wire [7:0] shifted = (word.shift == SH_LEFT) ? sh_left
		: (word.shift == SH_RIGHT) ? sh_right
		: (word.shift == SH_SWAP) ? sh_swap : core;
	wire shift_out = (word.shift == SH_LEFT) ? core[msb]
		: (word.shift == SH_RIGHT) ? core[0] : 1'b0;
	wire [7:0] result = static_cfg.mask_en ? (shifted | static_cfg.or_mask)
		: shifted;

	assign chain_co = carry_out;
	assign chain_so = shift_out;
	//------------------------------------------------------------------
	// Compares and conditions
	//------------------------------------------------------------------
	genvar c;
	generate
		for (c = 0; c < 2; c++) begin : g_cmp
			wire [1:0] pair = static_cfg.cmp_pair[c];
			wire [7:0] x = acc_q[pair[0]];
			wire [7:0] y = (pair == PAIR_A0_A1) ? acc_q[1]
				: dreg_q[pair == PAIR_A1_D1];
			wire [7:0] m = static_cfg.cmp_mask[c];
			assign cmp_eq[c] = ((x ^ y) & m) == 8'h00;
			assign cmp_lt[c] = (x & m) < (y & m);
		end
	endgenerate

	wire ce0 = cmp_eq[0] & (static_cfg.chain_en ? chain_eq_in : 1'b1);
	assign chain_eq_out = ce0;
	wire [1:0] zero_det;
	wire [1:0] ones_det;
	assign zero_det[0] = (acc_q[0] & width_mask) == 8'h00;
	assign zero_det[1] = (acc_q[1] & width_mask) == 8'h00;
	assign ones_det[0] = (acc_q[0] | ~width_mask) == 8'hFF;
	assign ones_det[1] = (acc_q[1] | ~width_mask) == 8'hFF;
	assign cond = {1'b0, q_full[1], q_empty[1], q_full[0], q_empty[0],
		shift_q, carry_q, overflow, ones_det[1], ones_det[0],
		zero_det[1], zero_det[0], cmp_lt[1], cmp_eq[1], cmp_lt[0],
		ce0};
	genvar k;
	generate
		for (k = 0; k < ROUTE_OUTS; k++) begin : g_route
			assign route_pick[k] = cond[static_cfg.out_sel[k]];
		end
	endgenerate
	assign route_out = route_out_q;

	//------------------------------------------------------------------
	// Queue lanes with their accumulator and operand register
	//------------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_lane
			wire wr_acc = bus_req.wr && (bus_req.addr == ADDR_ACC[i]);
			wire wr_opr = bus_req.wr && (bus_req.addr == ADDR_OPR[i]);
			wire wr_buf = bus_req.wr && (bus_req.addr == ADDR_QUEUE[i]);
			wire rd_buf = bus_req.rd && (bus_req.addr == ADDR_QUEUE[i]);
			wire q_out  = static_cfg.q_out_dir[i];
			wire [1:0] src = word.acc_src[i];
			wire q_ready = !q_out && !q_empty[i];
			wire acc_take = q_ready && (src == ACC_QUEUE);
			wire opr_take = q_ready && word.dreg_load;
			wire pop = acc_take || opr_take || (q_out && rd_buf);
			wire push = q_out ? word.queue_push : wr_buf;
			wire [7:0] cap = static_cfg.q_cap_alu[i] ? result : acc_q[i];
			wire [7:0] push_data = q_out ? cap : bus_req.wdata;
			wire [7:0] acc_d = wr_acc ? bus_req.wdata
				: (src == ACC_ALU) ? result
				: acc_take ? q_head[i]
				: (src == ACC_OPERAND) ? dreg_q[i] : acc_q[i];
			wire [7:0] opr_d = wr_opr ? bus_req.wdata
				: opr_take ? q_head[i] : dreg_q[i];

			byte_queue #(
				.WIDTH (DATA_W),
				.DEPTH (QUEUE_DEPTH)
			) u_queue (
				.clk       (clk),
				.clk_en    (clk_en),
				.sys_rst   (sys_rst),
				.push      (push),
				.push_data (push_data),
				.pop       (pop),
				.head      (q_head[i]),
				.full      (q_full[i]),
				.empty     (q_empty[i])
			);

			always_ff @(posedge clk) begin
				if (sys_rst) begin
					acc_q[i]  <= BYTE_RESET;
					dreg_q[i] <= BYTE_RESET;
				end else if (clk_en) begin
					acc_q[i]  <= acc_d;
					dreg_q[i] <= opr_d;
				end
			end
		end
	endgenerate

	//------------------------------------------------------------------
	// Configuration store, carry and shift registers, bus read
	//------------------------------------------------------------------
	wire [7:0] status = {4'h0, q_full[1], q_empty[1], q_full[0], q_empty[0]};
	wire [7:0] rd_sel = (bus_req.addr == ADDR_ACC[0]) ? acc_q[0]
		: (bus_req.addr == ADDR_ACC[1]) ? acc_q[1]
		: (bus_req.addr == ADDR_OPR[0]) ? dreg_q[0]
		: (bus_req.addr == ADDR_OPR[1]) ? dreg_q[1]
		: (bus_req.addr == ADDR_QUEUE[0]) ? q_head[0]
		: (bus_req.addr == ADDR_QUEUE[1]) ? q_head[1]
		: (bus_req.addr == ADDR_STATUS) ? status : 8'h00;
	assign bus_rdata = rdata_q;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int w = 0; w < CFG_WORDS; w++) begin
				cfg_ram_q[w] <= CFG_RESET;
			end
		end else if (clk_en && cfg_we) begin
			cfg_ram_q[cfg_addr] <= cfg_wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			carry_q     <= 1'b0;
			shift_q     <= 1'b0;
			route_out_q <= '0;
			rdata_q     <= BYTE_RESET;
		end else if (clk_en) begin
			carry_q     <= carry_out;
			shift_q     <= shift_out;
			route_out_q <= route_pick;
			rdata_q     <= bus_req.rd ? rd_sel : rdata_q;
		end
	end

	//------------------------------------------------------------------
	// Checks
	//------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire base_case = clk_en && word.shift == SH_NONE && !word.a_sel
		&& !static_cfg.mask_en && msb == MSB_TOP
		&& word.acc_src[0] == ACC_ALU && !g_lane[0].wr_acc;
	wire add_case = base_case && word.op == OP_ADD && !word.crc_en
		&& word.b_sel == 2'h0;
	wire crc_case = base_case && word.crc_en;
	wire [7:0] add_ref = opa + dreg_q[0] + {7'h00, cin};
	wire [7:0] crc_ref = {opa[6:0], 1'b0}
		^ ((opa[7] ^ sin) ? static_cfg.poly : 8'h00);
	acc_reset_a: assert property ($fell(sys_rst) |->
		acc_q[0] == BYTE_RESET && dreg_q[1] == BYTE_RESET && !carry_q)
		else $error("state not cleared by reset");
	alu_add_a: assert property (add_case |=>
		acc_q[0] == $past(add_ref))
		else $error("add result not in accumulator next cycle");
	crc_step_a: assert property (crc_case |=>
		acc_q[0] == $past(crc_ref))
		else $error("crc step result wrong");
	opr_hold_a: assert property (clk_en && !word.dreg_load
		&& !g_lane[0].wr_opr |=> $stable(dreg_q[0]))
		else $error("operand register changed without a load");
	cfg_store_a: assert property (clk_en && cfg_we |=>
		cfg_ram_q[$past(cfg_addr)] == $past(cfg_wdata))
		else $error("configuration word not stored");
	carry_feed_a: assert property (clk_en ##1 word.carry_reg |->
		cin == $past(carry_out))
		else $error("registered carry not fed back");
	zero_route_a: assert property (clk_en
		&& static_cfg.out_sel[0] == COND_ZERO0 |=>
		route_out[0] == ($past(acc_q[0] & width_mask) == 8'h00))
		else $error("zero condition not routed out");
	add_run_c: cover property (add_case ##1 add_case);
	crc_run_c: cover property (crc_case);
	bus_pop_c: cover property (g_lane[0].q_out && g_lane[0].rd_buf
		&& !q_empty[0]);
endmodule

// ---- sim/neighbour_model.sv ----
// Behavioural neighbour tile that feeds the chaining inputs.
module neighbour_model (
	input  wire logic clk,
	input  wire logic co,
	output logic      ci,
	output logic      si,
	output logic      eq
);
	timeunit 1ns;
	timeprecision 1ps;
	// The neighbour takes our carry back one cycle later and reports equal.
	initial ci = 1'b0;
	always @(posedge clk) begin
		ci <= co;
	end
	assign si = 1'b0;
	assign eq = 1'b1;
endmodule

// ---- sim/programmable_logic_datapath_bench.sv ----
// Self-checking bench for the configurable logic tile.
module programmable_logic_datapath_bench import dp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic                    clk = 1'b0;
	logic                    sys_rst;
	logic                    clk_en;
	bus_req_s                bus_req;
	logic [7:0]              bus_rdata;
	logic                    cfg_we;
	logic [2:0]              cfg_addr;
	cfg_word_s               cfg_wdata;
	static_cfg_s             static_cfg;
	pla_cfg_s [1:0]          pla_cfg;
	logic [1:0][11:0]        pla_in;
	logic [1:0][3:0]         pla_out;
	logic [2:0]              route_addr;
	logic                    route_ci;
	logic [5:0]              route_out;
	logic                    chain_ci;
	logic                    chain_si;
	logic                    chain_eq_in;
	logic                    chain_co;
	logic                    chain_eq_out;
	int                      fail_count = 0;
	int                      n_checks = 0;
	alu_op_e    ops [11] = '{OP_PASS, OP_INC, OP_DEC, OP_ADD, OP_SUB, OP_AND,
		OP_OR, OP_XOR, OP_PASS, OP_PASS, OP_PASS};
	shift_e     shs [11] = '{SH_NONE, SH_NONE, SH_NONE, SH_NONE, SH_NONE,
		SH_NONE, SH_NONE, SH_NONE, SH_LEFT, SH_RIGHT, SH_SWAP};
	logic [7:0] exps [11] = '{8'h5A, 8'h5B, 8'h59, 8'h96, 8'h1E, 8'h18,
		8'h7E, 8'h66, 8'hB4, 8'h2D, 8'hA5};

	always #5 clk = ~clk;

	programmable_logic_datapath i_dut (
		.clk(clk), .clk_en(clk_en), .sys_rst(sys_rst), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
		.cfg_wdata(cfg_wdata), .static_cfg(static_cfg), .pla_cfg(pla_cfg),
		.pla_in(pla_in), .pla_out(pla_out), .route_addr(route_addr),
		.route_ci(route_ci), .route_si(1'b0), .route_out(route_out),
		.chain_ci(chain_ci), .chain_si(chain_si),
		.chain_eq_in(chain_eq_in), .chain_co(chain_co), .chain_so(),
		.chain_eq_out(chain_eq_out)
	);

	neighbour_model i_nb (
		.clk(clk), .co(chain_co), .ci(chain_ci), .si(chain_si),
		.eq(chain_eq_in)
	);

	//------------------------------------------------------------------
	// Access tasks
	//------------------------------------------------------------------
	task automatic check(string what, logic [7:0] exp, logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(logic [2:0] a, logic [7:0] d);
		@(negedge clk);
		bus_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge clk);
		bus_req = '0;
	endtask

	task automatic rdchk(string what, logic [2:0] a, logic [7:0] e);
		@(negedge clk);
		bus_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge clk);
		bus_req = '0;
		check(what, e, bus_rdata);
	endtask

	// Stores the word in slot one and selects it for n cycles in a row.
	task automatic run(cfg_word_s w, logic ci, int n = 1);
		@(negedge clk);
		cfg_we = 1'b1;
		cfg_addr = 3'h1;
		cfg_wdata = w;
		@(negedge clk);
		cfg_we = 1'b0;
		route_addr = 3'h1;
		route_ci = ci;
		repeat (n) @(negedge clk);
		route_addr = 3'h0;
		route_ci = 1'b0;
	endtask

	task automatic conclude();
		if (fail_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	//------------------------------------------------------------------
	// Tests
	//------------------------------------------------------------------
	initial begin
		#100us;
		fail_count++;
		conclude();
	end

	initial begin
		cfg_word_s w;
		sys_rst = 1'b1;
		clk_en = 1'b1;
		bus_req = '0;
		cfg_we = 1'b0;
		cfg_addr = 3'h0;
		cfg_wdata = '0;
		static_cfg = '0;
		static_cfg.msb = MSB_TOP;
		static_cfg.out_sel[0] = COND_ZERO0;
		static_cfg.cmp_mask[0] = 8'hFF;
		pla_cfg = '0;
		pla_in = '0;
		route_addr = 3'h0;
		route_ci = 1'b0;
		repeat (20) @(negedge clk);
		sys_rst = 1'b0;
		rdchk("acc0", ADDR_ACC[0], BYTE_RESET);
		rdchk("opr1", ADDR_OPR[1], BYTE_RESET);
		rdchk("status", ADDR_STATUS, 8'h05);
		check("route0", 8'h01, {7'h0, route_out[0]});
		check("chain_eq", 8'h01, {7'h0, chain_eq_out});
		for (int i = 0; i < 11; i++) begin
			wr(ADDR_ACC[0], 8'h5A);
			wr(ADDR_OPR[0], 8'h3C);
			w = '0;
			w.op = ops[i];
			w.shift = shs[i];
			w.acc_src[0] = ACC_ALU;
			run(w, ops[i] == OP_SUB);
			rdchk("alu", ADDR_ACC[0], exps[i]);
		end
		rdchk("opr0", ADDR_OPR[0], 8'h3C);
		rdchk("acc1", ADDR_ACC[1], 8'h00);
		check("route0", 8'h00, {7'h0, route_out[0]});
		check("chain_eq", 8'h00, {7'h0, chain_eq_out});
		for (int i = 0; i < 5; i++)
			wr(ADDR_QUEUE[0], 8'(i) + 8'hC0);
		rdchk("status", ADDR_STATUS, 8'h06);
		rdchk("peek", ADDR_QUEUE[0], 8'hC0);
		w = '0;
		w.dreg_load = 1'b1;
		run(w, 1'b0);
		rdchk("opr0", ADDR_OPR[0], 8'hC0);
		w = '0;
		w.acc_src[0] = ACC_QUEUE;
		run(w, 1'b0);
		rdchk("acc0", ADDR_ACC[0], 8'hC1);
		w = '0;
		w.dreg_load = 1'b1;
		run(w, 1'b0);
		run(w, 1'b0);
		rdchk("opr0", ADDR_OPR[0], 8'hC3);
		rdchk("status", ADDR_STATUS, 8'h05);
		static_cfg.q_out_dir = 2'b10;
		static_cfg.q_cap_alu = 2'h2;
		w = '0;
		w.queue_push = 1'b1;
		run(w, 1'b0);
		rdchk("status", ADDR_STATUS, 8'h01);
		rdchk("queue1", ADDR_QUEUE[1], 8'hC1);
		wr(ADDR_QUEUE[1], 8'h77);
		rdchk("status", ADDR_STATUS, 8'h05);
		clk_en = 1'b0;
		wr(ADDR_OPR[1], 8'h99);
		clk_en = 1'b1;
		rdchk("frozen", ADDR_OPR[1], BYTE_RESET);
		wr(ADDR_ACC[0], 8'hFF);
		wr(ADDR_OPR[0], 8'h01);
		w = '0;
		w.op = OP_ADD;
		w.acc_src[0] = ACC_ALU;
		w.carry_reg = 1'b1;
		run(w, 1'b0, 2);
		rdchk("carry", ADDR_ACC[0], 8'h02);
		wr(ADDR_ACC[0], 8'h81);
		static_cfg.poly = 8'h07;
		w = '0;
		w.crc_en = 1'b1;
		w.acc_src[0] = ACC_ALU;
		run(w, 1'b0);
		rdchk("crc", ADDR_ACC[0], 8'h05);
		@(negedge clk);
		pla_cfg[0].use_true[0][0] = 1'b1;
		pla_cfg[0].sum_en[0][0] = 1'b1;
		pla_in[0] = 12'h001;
		#1 check("pla", 8'h01, {7'h0, pla_out[0][0]});
		@(negedge clk);
		pla_in[0] = 12'h000;
		#1 check("pla", 8'h00, {7'h0, pla_out[0][0]});
		@(negedge clk);
		pla_cfg[0].reg_out[0] = 1'b1;
		pla_in[0] = 12'h001;
		#1 check("pla", 8'h00, {7'h0, pla_out[0][0]});
		@(negedge clk);
		check("pla", 8'h01, {7'h0, pla_out[0][0]});
		conclude();
	end
endmodule
